/* File: include/taos_pkg.sv */
// Constants for the auxiliary test output register group
package taos_pkg;
  localparam int               REG_ADDR_WIDTH       = 6;
  localparam int               REG_DATA_WIDTH       = 8;
  localparam int               LEVEL_WIDTH          = 6;
  localparam int               PROBE_WIDTH          = 8;
  localparam int               PROBE_SEL_WIDTH      = 3;
  // Register offsets
  localparam logic [5:0]       SILICON_REVISION_ADDR = 6'h37;
  localparam logic [5:0]       AUX_OUTPUT_SELECT_ADDR = 6'h38;
  localparam logic [5:0]       TEST_LEVEL_ONE_ADDR  = 6'h39;
  localparam logic [5:0]       TEST_LEVEL_TWO_ADDR  = 6'h3a;
  // Reset values
  localparam logic [7:0]       AUX_OUTPUT_SELECT_RESET = 8'h00;
  localparam logic [5:0]       TEST_LEVEL_RESET     = 6'h00;
  // Field positions of the select register
  localparam int               FIRST_SOURCE_MSB     = 7;
  localparam int               FIRST_SOURCE_LSB     = 4;
  localparam int               SECOND_SOURCE_MSB    = 3;
  localparam int               SECOND_SOURCE_LSB    = 0;
  // Source codes
  typedef enum logic [3:0] {
    SRC_TRISTATE   = 4'h0,
    SRC_TEST_LEVEL = 4'h1,
    SRC_CORR_ONE   = 4'h2,
    SRC_CORR_TWO   = 4'h3,
    SRC_MIN_THRESH = 4'h4,
    SRC_CONV_I     = 4'h5,
    SRC_CONV_Q     = 4'h6,
    SRC_PROD_A     = 4'h7,
    SRC_PROD_B     = 4'h8,
    SRC_SECURE_CLK = 4'h9,
    SRC_HIGH       = 4'ha,
    SRC_LOW        = 4'hb,
    SRC_TX_ACTIVE  = 4'hc,
    SRC_RX_ACTIVE  = 4'hd,
    SRC_SUBCARRIER = 4'he,
    SRC_PROBE_BIT  = 4'hf
  } taos_source_type;
endpackage : taos_pkg

/* File: src/taos_aux_select.sv */
// Auxiliary test output register group and pin source selection
`timescale 1ns/1ns
`default_nettype none

module taos_aux_select
  import taos_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  // Register access from the host interface
  input  wire logic                                 reg_write_in,
  input  wire logic [taos_pkg::REG_ADDR_WIDTH-1:0]  reg_addr_in,
  input  wire logic [taos_pkg::REG_DATA_WIDTH-1:0]  reg_wdata_in,
  output logic      [taos_pkg::REG_DATA_WIDTH-1:0]  reg_rdata_out,
  // Probe bit select field of the first test select register
  input  wire logic [taos_pkg::PROBE_SEL_WIDTH-1:0] probe_bit_select_in,
  // Internal signals, all on the device clock
  input  wire logic                                 correlator_one_signal_in,
  input  wire logic                                 correlator_two_signal_in,
  input  wire logic                                 minimum_threshold_signal_in,
  input  wire logic                                 converter_i_signal_in,
  input  wire logic                                 converter_q_signal_in,
  input  wire logic                                 production_test_a_in,
  input  wire logic                                 production_test_b_in,
  input  wire logic                                 secure_clock_in,
  input  wire logic                                 transmit_in_progress_in,
  input  wire logic                                 receive_in_progress_in,
  input  wire logic                                 subcarrier_detected_in,
  input  wire logic [taos_pkg::PROBE_WIDTH-1:0]     probe_bus_in,
  // Auxiliary pins: enable low while driven
  output logic      [taos_pkg::LEVEL_WIDTH-1:0]     first_auxiliary_pin_out,
  output logic                                      first_auxiliary_pin_oe_n_out,
  output logic      [taos_pkg::LEVEL_WIDTH-1:0]     second_auxiliary_pin_out,
  output logic                                      second_auxiliary_pin_oe_n_out
);
  import taos_pkg::*;

  // Two pins, each steered by its own four-bit source field
  localparam int PIN_COUNT         = 2;
  localparam int FIRST_PIN         = 0;
  localparam int SECOND_PIN        = 1;
  localparam int SOURCE_CODE_WIDTH = $bits(taos_source_type);
  localparam int SOURCE_COUNT      = 1 << SOURCE_CODE_WIDTH;
  localparam int RESERVED_WIDTH    = REG_DATA_WIDTH - LEVEL_WIDTH;

  // Elaboration checks on the package constants
  if (PROBE_WIDTH != (1 << PROBE_SEL_WIDTH))
  begin : g_check_probe
    $error("Probe bus width must match the select field");
  end
  if (LEVEL_WIDTH >= REG_DATA_WIDTH)
  begin : g_check_level
    $error("Level field must leave reserved bits in its register");
  end
  if ((2 * SOURCE_CODE_WIDTH) != REG_DATA_WIDTH)
  begin : g_check_select
    $error("Select register must hold exactly two source fields");
  end
  if ((FIRST_SOURCE_MSB - FIRST_SOURCE_LSB + 1) != SOURCE_CODE_WIDTH)
  begin : g_check_first_field
    $error("First source field width does not match the code width");
  end
  if ((SECOND_SOURCE_MSB - SECOND_SOURCE_LSB + 1) != SOURCE_CODE_WIDTH)
  begin : g_check_second_field
    $error("Second source field width does not match the code width");
  end
  if (REG_ADDR_WIDTH != $bits(SILICON_REVISION_ADDR))
  begin : g_check_addr
    $error("Register offsets must match the address width");
  end

  // Address decode
  logic                         hit_revision;
  logic                         hit_select;
  logic                         hit_level_one;
  logic                         hit_level_two;

  // Register state and next values
  logic [REG_DATA_WIDTH-1:0]    aux_output_select_q;
  logic [REG_DATA_WIDTH-1:0]    aux_output_select_d;
  logic [LEVEL_WIDTH-1:0]       test_level_one_q;
  logic [LEVEL_WIDTH-1:0]       test_level_one_d;
  logic [LEVEL_WIDTH-1:0]       test_level_two_q;
  logic [LEVEL_WIDTH-1:0]       test_level_two_d;
  logic [REG_DATA_WIDTH-1:0]    rdata_d;
  logic [REG_DATA_WIDTH-1:0]    rdata_q;

  // One-bit sources indexed by code, and per-pin routing
  logic [SOURCE_COUNT-1:0]      source_bit;
  logic [SOURCE_CODE_WIDTH-1:0] pin_code  [PIN_COUNT];
  logic [LEVEL_WIDTH-1:0]       pin_level [PIN_COUNT];
  logic [LEVEL_WIDTH-1:0]       pin_value [PIN_COUNT];
  logic                         pin_oe_n  [PIN_COUNT];

  // Address decode; the revision hit only ever feeds the read path
  always_comb
  begin
    hit_revision  = 1'b0;
    hit_select    = 1'b0;
    hit_level_one = 1'b0;
    hit_level_two = 1'b0;
    if (reg_addr_in == SILICON_REVISION_ADDR)
    begin
      hit_revision = 1'b1;
    end
    else if (reg_addr_in == AUX_OUTPUT_SELECT_ADDR)
    begin
      hit_select = 1'b1;
    end
    else if (reg_addr_in == TEST_LEVEL_ONE_ADDR)
    begin
      hit_level_one = 1'b1;
    end
    else if (reg_addr_in == TEST_LEVEL_TWO_ADDR)
    begin
      hit_level_two = 1'b1;
    end
  end

  // Select register: both source fields are written as one byte
  always_comb
  begin
    aux_output_select_d = aux_output_select_q;
    if (reg_write_in && hit_select)
    begin
      aux_output_select_d = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aux_output_select_q <= AUX_OUTPUT_SELECT_RESET;
    end
    else
    begin
      aux_output_select_q <= aux_output_select_d;
    end
  end

  // Level registers keep only the level field; reserved bits are dropped
  always_comb
  begin
    test_level_one_d = test_level_one_q;
    test_level_two_d = test_level_two_q;
    if (reg_write_in && hit_level_one)
    begin
      test_level_one_d = reg_wdata_in[LEVEL_WIDTH-1:0];
    end
    if (reg_write_in && hit_level_two)
    begin
      test_level_two_d = reg_wdata_in[LEVEL_WIDTH-1:0];
    end
  end

  // Levels have no defined reset value; zero keeps the pins predictable
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      test_level_one_q <= TEST_LEVEL_RESET;
      test_level_two_q <= TEST_LEVEL_RESET;
    end
    else
    begin
      test_level_one_q <= test_level_one_d;
      test_level_two_q <= test_level_two_d;
    end
  end

  // Read data; unmapped offsets read zero
  always_comb
  begin
    rdata_d = '0;
    if (hit_revision)
    begin
      rdata_d = REVISION_CODE;
    end
    else if (hit_select)
    begin
      rdata_d = aux_output_select_q;
    end
    else if (hit_level_one)
    begin
      rdata_d = {{RESERVED_WIDTH{1'b0}}, test_level_one_q};
    end
    else if (hit_level_two)
    begin
      rdata_d = {{RESERVED_WIDTH{1'b0}}, test_level_two_q};
    end
  end

  // Registered read costs a cycle but keeps the host path glitch free
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Tristate and level codes carry no one-bit source; handled per pin
  always_comb
  begin
    source_bit                 = '0;
    source_bit[SRC_TRISTATE]   = 1'b0;
    source_bit[SRC_TEST_LEVEL] = 1'b0;
    source_bit[SRC_CORR_ONE]   = correlator_one_signal_in;
    source_bit[SRC_CORR_TWO]   = correlator_two_signal_in;
    source_bit[SRC_MIN_THRESH] = minimum_threshold_signal_in;
    source_bit[SRC_CONV_I]     = converter_i_signal_in;
    source_bit[SRC_CONV_Q]     = converter_q_signal_in;
    source_bit[SRC_PROD_A]     = production_test_a_in;
    source_bit[SRC_PROD_B]     = production_test_b_in;
    source_bit[SRC_SECURE_CLK] = secure_clock_in;
    source_bit[SRC_HIGH]       = 1'b1;
    source_bit[SRC_LOW]        = 1'b0;
    source_bit[SRC_TX_ACTIVE]  = transmit_in_progress_in;
    source_bit[SRC_RX_ACTIVE]  = receive_in_progress_in;
    source_bit[SRC_SUBCARRIER] = subcarrier_detected_in;
    source_bit[SRC_PROBE_BIT]  = probe_bus_in[probe_bit_select_in];
  end

  // Field extraction; the first pin owns the high nibble
  assign pin_code[FIRST_PIN]   = aux_output_select_q[FIRST_SOURCE_MSB:FIRST_SOURCE_LSB];
  assign pin_code[SECOND_PIN]  = aux_output_select_q[SECOND_SOURCE_MSB:SECOND_SOURCE_LSB];
  assign pin_level[FIRST_PIN]  = test_level_one_q;
  assign pin_level[SECOND_PIN] = test_level_two_q;

  // Routing stays combinational so the secure clock and flags are cycle-true
  for (genvar p = 0; p < PIN_COUNT; p++)
  begin : g_pin
    logic                   oe_n_v;
    logic [LEVEL_WIDTH-1:0] value_v;

    // One-bit sources are replicated across the whole pin value
    always_comb
    begin
      oe_n_v  = 1'b0;
      value_v = {LEVEL_WIDTH{source_bit[pin_code[p]]}};
      case (taos_source_type'(pin_code[p]))
        SRC_TRISTATE:
        begin
          oe_n_v  = 1'b1;
          value_v = '0;
        end
        SRC_TEST_LEVEL:
        begin
          value_v = pin_level[p];
        end
        default:
        begin
          oe_n_v = 1'b0;
        end
      endcase
    end

    assign pin_oe_n[p]  = oe_n_v;
    assign pin_value[p] = value_v;
  end

  // Output enable is low while a pin is driven
  assign first_auxiliary_pin_out       = pin_value[FIRST_PIN];
  assign first_auxiliary_pin_oe_n_out  = pin_oe_n[FIRST_PIN];
  assign second_auxiliary_pin_out      = pin_value[SECOND_PIN];
  assign second_auxiliary_pin_oe_n_out = pin_oe_n[SECOND_PIN];

endmodule : taos_aux_select
`default_nettype wire

/* File: bench/taos_aux_select_sva.sv */
// Checker for the auxiliary output register group
`timescale 1ns/1ns
`default_nettype none
module taos_aux_select_sva
  import taos_pkg::*;
#(parameter logic [7:0] REVISION_CODE = 8'h5a)
(
  // Clock, reset and register access
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       reg_write_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Probe and pins
  input wire logic [2:0] probe_bit_select_in,
  input wire logic [7:0] probe_bus_in,
  input wire logic [5:0] first_auxiliary_pin_out,
  input wire logic       first_auxiliary_pin_oe_n_out,
  input wire logic [5:0] second_auxiliary_pin_out,
  input wire logic       second_auxiliary_pin_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_sel;
    reg_write_in && reg_addr_in == AUX_OUTPUT_SELECT_ADDR;
  endsequence
  sequence wr_idle(logic [5:0] a);
    reg_write_in && reg_addr_in == a ##1 !reg_write_in && reg_addr_in == a;
  endsequence
  AST_REV_RO:
    assert property (reg_addr_in == SILICON_REVISION_ADDR |=> reg_rdata_out == REVISION_CODE)
    else $error("revision read wrong");
  AST_UNMAPPED:
    assert property (reg_addr_in < 6'h37 || reg_addr_in > 6'h3a |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_SEL_BACK:
    assert property (wr_idle(AUX_OUTPUT_SELECT_ADDR) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("select readback wrong");
  AST_LVL_ONE:
    assert property (wr_idle(TEST_LEVEL_ONE_ADDR) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h3f))
    else $error("level one readback wrong");
  AST_LVL_TWO:
    assert property (wr_idle(TEST_LEVEL_TWO_ADDR) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h3f))
    else $error("level two readback wrong");
  AST_TRI_ONE:
    assert property (wr_sel and reg_wdata_in[7:4] == 4'h0 |=> first_auxiliary_pin_oe_n_out)
    else $error("first pin not tristated");
  AST_HIGH_ONE:
    assert property (wr_sel and reg_wdata_in[7:4] == 4'ha
      |=> !first_auxiliary_pin_oe_n_out && first_auxiliary_pin_out == 6'h3f)
    else $error("first pin not high");
  AST_LOW_TWO:
    assert property (wr_sel and reg_wdata_in[3:0] == 4'hb
      |=> !second_auxiliary_pin_oe_n_out && second_auxiliary_pin_out == 6'h00)
    else $error("second pin not low");
  AST_PROBE_TWO:
    assert property (wr_sel and reg_wdata_in[3:0] == 4'hf |=> !second_auxiliary_pin_oe_n_out
      && second_auxiliary_pin_out == {6{probe_bus_in[probe_bit_select_in]}})
    else $error("second pin probe bit wrong");
endmodule : taos_aux_select_sva
bind taos_aux_select taos_aux_select_sva #(.REVISION_CODE(REVISION_CODE)) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_write_in(reg_write_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .probe_bit_select_in(probe_bit_select_in), .probe_bus_in(probe_bus_in),
  .first_auxiliary_pin_out(first_auxiliary_pin_out),
  .first_auxiliary_pin_oe_n_out(first_auxiliary_pin_oe_n_out),
  .second_auxiliary_pin_out(second_auxiliary_pin_out),
  .second_auxiliary_pin_oe_n_out(second_auxiliary_pin_oe_n_out));
`default_nettype wire

/* File: bench/taos_aux_select_tb.sv */
// Self-checking bench for the auxiliary output register group
`timescale 1ns/1ns
`default_nettype none
module taos_aux_select_tb;
  import taos_pkg::*;
  localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
  logic        clk_in, rst_n_in, we, oe1, oe2;
  logic [5:0]  addr, pin1, pin2;
  logic [7:0]  wdata, rdata, probe;
  logic [2:0]  psel;
  logic [12:0] src;
  int          miscompares, checked, seed, sel, lvl1, lvl2;
  taos_aux_select #(.REVISION_CODE(REV)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_write_in(we), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .probe_bit_select_in(psel), .correlator_one_signal_in(src[0]),
    .correlator_two_signal_in(src[1]), .minimum_threshold_signal_in(src[2]),
    .converter_i_signal_in(src[3]), .converter_q_signal_in(src[4]),
    .production_test_a_in(src[5]), .production_test_b_in(src[6]), .secure_clock_in(src[7]),
    .transmit_in_progress_in(src[10]), .receive_in_progress_in(src[11]),
    .subcarrier_detected_in(src[12]), .probe_bus_in(probe),
    .first_auxiliary_pin_out(pin1), .first_auxiliary_pin_oe_n_out(oe1),
    .second_auxiliary_pin_out(pin2), .second_auxiliary_pin_oe_n_out(oe2));
  // Codes 2..14 index src by code minus two; 10 and 11 are constants
  function automatic logic [7:0] pin_exp(int code, int lvl);
    case (code)
      0: return 8'h40;
      1: return 8'(lvl);
      10: return 8'h3f;
      11: return 8'h00;
      15: return {2'b00, {6{probe[psel]}}};
      default: return {2'b00, {6{src[code-2]}}};
    endcase
  endfunction : pin_exp
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_in);
    we = 1'b0;
    if (a == 6'h38) sel = d;
    if (a == 6'h39) lvl1 = d & 8'h3f;
    if (a == 6'h3a) lvl2 = d & 8'h3f;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    cmp(rdata, a == 6'h37 ? REV : a == 6'h38 ? 8'(sel) : a == 6'h39 ? 8'(lvl1) :
        a == 6'h3a ? 8'(lvl2) : 8'h00);
  endtask : rd
  task automatic pins();
    @(negedge clk_in);
    src = 13'($random(seed));
    probe = 8'($random(seed));
    psel = 3'($random(seed));
    #1;
    cmp({1'b0, oe1, pin1}, pin_exp(sel >> 4, lvl1));
    cmp({1'b0, oe2, pin2}, pin_exp(sel & 15, lvl2));
  endtask : pins
  task automatic complete_run();
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end
  initial
  begin
    {rst_n_in, we, addr, wdata, src, probe, psel} = '0;
    {seed, sel, lvl1, lvl2} = {32'd9, 96'd0};
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(6'h38);
    pins();
    wr(6'h37, 8'hff);
    rd(6'h37);
    wr(6'h3b, 8'h55);
    rd(6'h3b);
    wr(6'h39, 8'hff);
    wr(6'h3a, 8'hc0);
    rd(6'h39);
    rd(6'h3a);
    for (int c = 0; c < 16; c++)
    begin
      wr(6'h39, 8'($random(seed)));
      wr(6'h3a, 8'($random(seed)));
      wr(6'h38, {4'(c), 4'(15 - c)});
      rd(6'h38);
      repeat (6) pins();
    end
    complete_run();
  end
endmodule : taos_aux_select_tb
`default_nettype wire
